// ---- rtl/lrpbc_core.sv ----
// lrpbc_core: lcd control core, status flags, modes, clocking, pixel parse
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module lrpbc_core
  import lrpbc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire lrpbc_ev_t         ev,
  input  wire logic              fifo_empty,
  input  wire logic [31:0]       fifo_data,
  output logic                   fifo_rd,
  input  wire logic              pal_valid,
  input  wire logic [15:0]       pal_data,
  output logic                   pal_ready,
  output logic      [23:0]       pix_data,
  output logic                   pix_valid,
  output logic                   panel_clk,
  output logic                   pclk_tick,
  output logic                   mode_raster,
  output logic                   raster_on,
  output logic                   actvid_blank,
  output logic                   restart,
  output logic                   irq
);

  // ***************************************************
  // functions
  // ***************************************************
  function automatic logic [7:0] pix_extract(input logic [31:0] w,
                                             input logic [5:0]  sub,
                                             input logic [1:0]  lg,
                                             input logic        rev);
    logic [7:0]  width;
    logic [7:0]  shift;
    logic [31:0] sh;
    width = 8'h01 << lg;
    if (rev)
      shift = 8'(8'h20 - (8'(sub) + 8'h01) * width);
    else
      shift = 8'(8'(sub) * width);
    sh = w >> shift;
    return sh[7:0] & 8'((9'h001 << width) - 9'h001);
  endfunction

  function automatic logic [5:0] per_word(input lrpbc_fmt_t f,
                                          input logic [1:0] lg);
    unique case (f)
      FMT_ACT24P:             return 6'h04;
      FMT_ACT24U:             return 6'h01;
      FMT_ACT16, FMT_PC12,
      FMT_PC16:               return 6'h02;
      FMT_MONO4:              return 6'h08;
      FMT_MONO8:              return 6'h04;
      default:                return 6'(6'h20 >> lg);
    endcase
  endfunction

  // ***************************************************
  // registers
  // ***************************************************
  logic                 mode;
  logic                 auto_rs;
  logic                 run;
  logic [7:0]           div_reg;
  lrpbc_rcfg_t          rcfg;
  logic [BIAS_W-1:0]    bias_reload;
  logic [BIAS_W-1:0]    bias_cnt;
  logic [NUM_FLAGS-1:0] raw;
  logic [NUM_FLAGS-1:0] int_en;
  logic                 sel_masked;
  logic                 kick;
  lrpbc_eng_t           state;
  lrpbc_eng_t           next_state;
  logic [7:0]           pal_idx;
  logic [3:0]           pal_burst;
  logic [7:0]           pal_wait;
  logic [7:0]           next_wait;
  logic [15:0]          pal_ram [PAL_ENTRIES];
  logic [5:0]           sub;
  logic [31:0]          cur_word;
  logic [31:0]          word;
  logic [31:0]          sw;
  logic [7:0]           pidx;
  logic [15:0]          hw;
  logic [23:0]          next_pix;
  logic [NUM_FLAGS-1:0] set;
  logic [NUM_FLAGS-1:0] masked;
  logic [NUM_FLAGS-1:0] query;
  logic                 wr_ctrl;
  logic                 wr_rcfg;
  logic                 pal_take;
  logic                 pal_last;
  logic                 pix_go;
  logic                 need;
  logic                 uflow_evt;
  logic                 passive;
  logic                 bias_hit;
  logic                 tick;
  logic                 pclk;

  assign wr_ctrl  = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_rcfg  = reg_wr && (reg_addr == OFS_RCFG);
  assign masked   = raw & int_en;
  assign query    = sel_masked ? masked : raw;
  assign passive  = (rcfg.fmt == FMT_MONO4) || (rcfg.fmt == FMT_MONO8) ||
                    (rcfg.fmt == FMT_PC12) || (rcfg.fmt == FMT_PC16);

  // ***************************************************
  // clock divider
  // ***************************************************
  lrpbc_clkdiv #(
    .DIV_W   (8)
  ) u_div (
    .mclk    (mclk),
    .rst     (rst),
    .div     (div_reg),
    .min_div (mode ? DIV_MIN_RASTER : DIV_MIN_CHAR),
    .tick    (tick),
    .pclk    (pclk)
  );
  assign pclk_tick = tick;
  assign panel_clk = pclk;

  // ***************************************************
  // software registers
  // ***************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode        <= 1'b0;
      auto_rs     <= 1'b0;
      run         <= 1'b0;
      kick        <= 1'b0;
      div_reg     <= DIV_RST;
      rcfg        <= '0;
      bias_reload <= '0;
      int_en      <= '0;
      sel_masked  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode    <= reg_wdata[CTRL_MODE];
        auto_rs <= reg_wdata[CTRL_AUTO];
        run     <= reg_wdata[CTRL_RUN];
        kick    <= reg_wdata[CTRL_RUN] && !run && reg_wdata[CTRL_MODE];
      end else if (wr_rcfg) begin
        run  <= 1'b0;
        kick <= 1'b0;
      end else if (uflow_evt && !auto_rs) begin
        run <= 1'b0;
      end else if (state != ENG_IDLE) begin
        kick <= 1'b0;
      end
      if (wr_rcfg)
        rcfg <= lrpbc_rcfg_t'(reg_wdata[RCFG_W-1:0]);
      if (reg_wr && reg_addr == OFS_DIV)
        div_reg <= reg_wdata[7:0];
      if (reg_wr && reg_addr == OFS_BIAS)
        bias_reload <= reg_wdata[BIAS_W-1:0];
      if (reg_wr && reg_addr == OFS_INT_EN)
        int_en <= reg_wdata[NUM_FLAGS-1:0];
      if (reg_wr && reg_addr == OFS_SEL)
        sel_masked <= reg_wdata[0];
    end
  end

  // read data in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= ZERO_WORD;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL:   reg_rdata <= 32'({run, auto_rs, mode});
        OFS_DIV:    reg_rdata <= 32'(div_reg);
        OFS_RCFG:   reg_rdata <= 32'(rcfg);
        OFS_BIAS:   reg_rdata <= 32'({bias_cnt, bias_reload});
        OFS_RAW:    reg_rdata <= 32'(raw);
        OFS_MASKED: reg_rdata <= 32'(masked);
        OFS_INT_EN: reg_rdata <= 32'(int_en);
        OFS_SEL:    reg_rdata <= 32'(sel_masked);
        OFS_QUERY:  reg_rdata <= 32'(query);
        default:    reg_rdata <= ZERO_WORD;
      endcase
    end else begin
      reg_rdata <= ZERO_WORD;
    end
  end

  // ***************************************************
  // status flags and interrupt line
  // ***************************************************
  always_comb begin
    set           = '0;
    set[ST_XFER]  = ev.xfer_done && !mode;
    set[ST_FRAME] = ev.frame_done && mode;
    set[ST_SYNC]  = ev.sync_lost && mode && run;
    set[ST_BIAS]  = bias_hit;
    set[ST_UFLOW] = uflow_evt;
    set[ST_PAL]   = pal_take && pal_last;
    set[ST_EOF0]  = ev.eof0 && mode;
    set[ST_EOF1]  = ev.eof1 && mode;
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      raw <= '0;
      irq <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFS_RAW)
        raw <= (raw & ~reg_wdata[NUM_FLAGS-1:0]) | set;
      else
        raw <= raw | set;
      irq <= |masked;
    end
  end

  // ***************************************************
  // bias transition counter
  // ***************************************************
  assign bias_hit = ev.bias_edge && mode && run && passive &&
                    (bias_reload != '0) && !raw[ST_BIAS] &&
                    (bias_cnt <= 4'h1);

  always_ff @(posedge mclk) begin
    if (rst) begin
      bias_cnt <= '0;
    end else if (reg_wr && reg_addr == OFS_BIAS) begin
      bias_cnt <= reg_wdata[BIAS_W-1:0];
    end else if (bias_hit) begin
      bias_cnt <= bias_reload;
    end else if (ev.bias_edge && mode && run && passive &&
                 !raw[ST_BIAS] && bias_cnt != '0) begin
      bias_cnt <= bias_cnt - 1'b1;
    end
  end

  // ***************************************************
  // raster engine sequence
  // ***************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ENG_IDLE:
        if (kick && run && mode)
          next_state = rcfg.data_only ? ENG_PIX : ENG_PAL;
      ENG_PAL:
        if (!run)
          next_state = ENG_IDLE;
        else if (pal_take && pal_last)
          next_state = rcfg.pal_only ? ENG_IDLE : ENG_PIX;
      ENG_PIX:
        if (uflow_evt && !auto_rs)
          next_state = ENG_IDLE;
        else if (!run && ev.frame_done)
          next_state = ENG_IDLE;
      default:
        next_state = ENG_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state        <= ENG_IDLE;
      mode_raster  <= 1'b0;
      raster_on    <= 1'b0;
      actvid_blank <= 1'b0;
    end else begin
      state        <= next_state;
      mode_raster  <= mode;
      raster_on    <= run && mode;
      actvid_blank <= rcfg.actvid_blank;
    end
  end

  // ***************************************************
  // palette load pacing
  // ***************************************************
  assign pal_take = pal_valid && pal_ready;
  assign pal_last = pal_idx == ((rcfg.pal_bpp_log == LG_8BPP) ?
                                PAL_LAST_LARGE : PAL_LAST_SMALL);

  always_comb begin
    if (state != ENG_PAL)
      next_wait = '0;
    else if (pal_wait != '0)
      next_wait = pal_wait - 1'b1;
    else if (pal_take && pal_burst == BURST_LAST)
      next_wait = rcfg.pal_delay;
    else
      next_wait = '0;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pal_idx   <= '0;
      pal_burst <= '0;
      pal_wait  <= '0;
      pal_ready <= 1'b0;
    end else begin
      pal_wait  <= next_wait;
      pal_ready <= (next_state == ENG_PAL) && (next_wait == '0);
      if (state != ENG_PAL) begin
        pal_idx   <= '0;
        pal_burst <= '0;
      end else if (pal_take) begin
        pal_idx   <= pal_idx + 1'b1;
        pal_burst <= pal_burst + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (pal_take)
      pal_ram[pal_idx] <= pal_data;
  end

  // ***************************************************
  // pixel parsing
  // ***************************************************
  assign pix_go    = (state == ENG_PIX) && tick;
  assign need      = (rcfg.fmt == FMT_ACT24P) ? (sub != PH_24P_NOREAD) :
                                                (sub == '0);
  assign uflow_evt = pix_go && need && fifo_empty;

  always_comb begin
    word     = need ? fifo_data : cur_word;
    sw       = rcfg.nibble ? {word[7:0], word[15:8], word[23:16],
                              word[31:24]} : word;
    hw       = sub[0] ? word[31:16] : word[15:0];
    pidx     = pix_extract(sw, sub, rcfg.pal_bpp_log, rcfg.rev_order);
    next_pix = '0;
    unique case (rcfg.fmt)
      FMT_ACT24P:
        unique case (sub[1:0])
          2'h0:    next_pix = word[23:0];
          2'h1:    next_pix = {word[15:0], cur_word[31:24]};
          2'h2:    next_pix = {word[7:0], cur_word[31:16]};
          default: next_pix = cur_word[31:8];
        endcase
      FMT_ACT24U: next_pix = word[23:0];
      FMT_ACT16:  next_pix = 24'(hw);
      FMT_PAL12:  next_pix = 24'(pal_ram[pidx][11:0]);
      FMT_PAL16:  next_pix = 24'(pal_ram[pidx]);
      FMT_MONO4:  next_pix = 24'(pix_extract(sw, sub, 2'h2,
                                             rcfg.rev_order));
      FMT_MONO8:  next_pix = 24'(pix_extract(sw, sub, 2'h3,
                                             rcfg.rev_order));
      FMT_PC12:   next_pix = 24'(hw[11:0]);
      FMT_PC16:   next_pix = 24'({hw[15:12], hw[10:7], hw[4:1]});
      default:    next_pix = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sub       <= '0;
      cur_word  <= ZERO_WORD;
      pix_data  <= '0;
      pix_valid <= 1'b0;
      fifo_rd   <= 1'b0;
      restart   <= 1'b0;
    end else begin
      pix_valid <= pix_go && !uflow_evt;
      fifo_rd   <= pix_go && need && !fifo_empty;
      restart   <= uflow_evt && auto_rs;
      if (state != ENG_PIX || uflow_evt) begin
        sub <= '0;
      end else if (pix_go) begin
        pix_data <= next_pix;
        if (need)
          cur_word <= fifo_data;
        if (sub == per_word(rcfg.fmt, rcfg.pal_bpp_log) - 1'b1)
          sub <= '0;
        else
          sub <= sub + 1'b1;
      end
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  property p_query;
    @(posedge mclk) disable iff (rst)
      (reg_rd && reg_addr == OFS_QUERY) |=> reg_rdata[7:0] == $past(query);
  endproperty
  a_query: assert property (p_query) else $error("status query wrong");

  property p_xfer;
    @(posedge mclk) disable iff (rst)
      (ev.xfer_done && !mode) |=> raw[ST_XFER];
  endproperty
  a_xfer: assert property (p_xfer) else $error("xfer flag missed");

  property p_bias;
    @(posedge mclk) disable iff (rst)
      (bias_hit && !(reg_wr && reg_addr == OFS_BIAS)) |=>
        raw[ST_BIAS] && bias_cnt == $past(bias_reload);
  endproperty
  a_bias: assert property (p_bias) else $error("bias reload wrong");

  property p_uflow;
    @(posedge mclk) disable iff (rst)
      uflow_evt |=> raw[ST_UFLOW] && !pix_valid && !fifo_rd;
  endproperty
  a_uflow: assert property (p_uflow) else $error("underflow missed");

  property p_restart;
    @(posedge mclk) disable iff (rst)
      (uflow_evt && !wr_ctrl && !wr_rcfg) |=>
        (run == ($past(run) && $past(auto_rs))) &&
        (restart == $past(auto_rs));
  endproperty
  a_restart: assert property (p_restart) else $error("restart wrong");

  property p_rate;
    @(posedge mclk) disable iff (rst)
      (tick && mode && $stable(div_reg)) |=> !tick;
  endproperty
  a_rate: assert property (p_rate) else $error("pixel clock too fast");

  property p_burst_wait;
    @(posedge mclk) disable iff (rst)
      (state == ENG_PAL && pal_take && pal_burst == BURST_LAST &&
       rcfg.pal_delay != '0 && !pal_last) |=>
        !pal_ready && pal_wait == $past(rcfg.pal_delay);
  endproperty
  a_burst_wait: assert property (p_burst_wait) else $error("no wait");

  property p_24p;
    @(posedge mclk) disable iff (rst)
      (pix_go && rcfg.fmt == FMT_ACT24P && sub == PH_24P_NOREAD) |=>
        !fifo_rd && pix_valid;
  endproperty
  a_24p: assert property (p_24p) else $error("packed read wrong");

  property p_cfg_stop;
    @(posedge mclk) disable iff (rst)
      (wr_rcfg && run) |=> !run ##1 !raster_on;
  endproperty
  a_cfg_stop: assert property (p_cfg_stop) else $error("still running");

  property p_irq;
    @(posedge mclk) disable iff (rst)
      ((raw & int_en) == '0) [*2] |-> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without source");

endmodule
`default_nettype wire

// ---- common/lrpbc_pkg.sv ----
// lrpbc_pkg: register map, field layouts and types of the lcd control core
package lrpbc_pkg;

  // ***************************************************
  // register map (byte addresses)
  // ***************************************************
  localparam int         ADDR_W     = 6;
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_DIV    = 6'h04;
  localparam logic [5:0] OFS_RCFG   = 6'h08;
  localparam logic [5:0] OFS_BIAS   = 6'h0C;
  localparam logic [5:0] OFS_RAW    = 6'h10;
  localparam logic [5:0] OFS_MASKED = 6'h14;
  localparam logic [5:0] OFS_INT_EN = 6'h18;
  localparam logic [5:0] OFS_SEL    = 6'h1C;
  localparam logic [5:0] OFS_QUERY  = 6'h20;

  // control register fields
  localparam int CTRL_MODE = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_RUN  = 2;

  // status flag positions
  localparam int ST_XFER   = 0;
  localparam int ST_FRAME  = 1;
  localparam int ST_SYNC   = 2;
  localparam int ST_BIAS   = 3;
  localparam int ST_UFLOW  = 4;
  localparam int ST_PAL    = 5;
  localparam int ST_EOF0   = 6;
  localparam int ST_EOF1   = 7;
  localparam int NUM_FLAGS = 8;

  // ***************************************************
  // reset values and limits
  // ***************************************************
  localparam logic [7:0]  DIV_RST        = 8'h02;
  localparam logic [7:0]  DIV_MIN_CHAR   = 8'h01;
  localparam logic [7:0]  DIV_MIN_RASTER = 8'h02;
  localparam int          BIAS_W         = 4;
  localparam logic [3:0]  BURST_LAST     = 4'hF;
  localparam logic [7:0]  PAL_LAST_SMALL = 8'h0F;
  localparam logic [7:0]  PAL_LAST_LARGE = 8'hFF;
  localparam int          PAL_ENTRIES    = 256;
  localparam logic [1:0]  LG_8BPP        = 2'h3;
  localparam logic [5:0]  PH_24P_NOREAD  = 6'h03;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [3:0] {
    FMT_ACT24P  = 4'h0,
    FMT_ACT24U  = 4'h1,
    FMT_ACT16   = 4'h2,
    FMT_PAL12   = 4'h3,
    FMT_PAL16   = 4'h4,
    FMT_MONO4   = 4'h5,
    FMT_MONO8   = 4'h6,
    FMT_PC12    = 4'h7,
    FMT_PC16    = 4'h8
  } lrpbc_fmt_t;

  // raster configuration word, low bits of the register
  typedef struct packed {
    logic [7:0] pal_delay;
    logic [1:0] pal_bpp_log;
    logic       rev_order;
    logic       pal_only;
    logic       data_only;
    logic       nibble;
    logic       actvid_blank;
    lrpbc_fmt_t fmt;
  } lrpbc_rcfg_t;
  localparam int RCFG_W = $bits(lrpbc_rcfg_t);

  // events from the surrounding controller, one-cycle pulses
  typedef struct packed {
    logic xfer_done;
    logic frame_done;
    logic sync_lost;
    logic eof0;
    logic eof1;
    logic bias_edge;
  } lrpbc_ev_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_PAL  = 2'b01,
    ENG_PIX  = 2'b11
  } lrpbc_eng_t;

endpackage

// ---- rtl/lrpbc_clkdiv.sv ----
// lrpbc_clkdiv: integer divider for the panel master / pixel clock
`timescale 1ns/10ps
`default_nettype none
module lrpbc_clkdiv #(
  parameter int DIV_W = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [DIV_W-1:0] div,
  input  wire logic [DIV_W-1:0] min_div,
  output logic                  tick,
  output logic                  pclk
);

  logic [DIV_W-1:0] eff;
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic [DIV_W-1:0] high_len;

  // divisors below the mode minimum run at the minimum
  assign eff      = (div < min_div) ? min_div : div;
  assign next_cnt = (cnt >= eff - 1'b1) ? '0 : cnt + 1'b1;
  assign high_len = DIV_W'(({1'b0, eff} + 1'b1) >> 1);

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt  <= '0;
      tick <= 1'b0;
      pclk <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= (next_cnt == '0);
      pclk <= (next_cnt < high_len);
    end
  end

endmodule
`default_nettype wire

// ---- dv/lrpbc_panel_src.sv ----
// lrpbc_panel_src: pixel fifo and palette source facing the core
`timescale 1ns/10ps
`default_nettype none
module lrpbc_panel_src (
  input  wire logic        mclk,
  input  wire logic        fill,
  input  wire logic        fifo_rd,
  output logic             fifo_empty,
  output logic      [31:0] fifo_data,
  output logic             pal_valid,
  output logic      [15:0] pal_data
);
  logic [7:0] left;
  assign fifo_empty = (left == 8'h00);
  // pad byte all ones so ignored bits show; empty head is junk
  assign fifo_data = fifo_empty ? 32'h003C_FFFB : {16'hFFC3, 8'h00, left};
  assign pal_valid = 1'b1;
  assign pal_data = 16'h0ABC;
  always_ff @(posedge mclk) begin
    if (fill)
      left <= 8'h04;
    else if (fifo_rd && !fifo_empty)
      left <= left - 8'h01;
  end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// tb: self-checking bench of the lcd control core
`timescale 1ns/10ps
`default_nettype none
module tb
  import lrpbc_pkg::*;
;
  typedef struct {logic [5:0] a; logic [31:0] d; logic [31:0] e;} lrpbc_row_t;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        fill = 1'b1;
  logic [5:0]  reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  lrpbc_ev_t   ev = '0;
  logic [31:0] reg_rdata, fifo_data;
  logic [15:0] pal_data;
  logic [23:0] pix_data;
  logic        fifo_empty, fifo_rd, pal_valid, pix_valid;
  logic        raster_on, restart, irq;
  logic        pclk_tick, mode_raster, actvid_blank;
  int          gap = 0;
  int          mismatches = 0;
  int          checks = 0;
  int          cyc = 0;
  lrpbc_row_t  rows [3] = '{
    '{OFS_DIV, 32'h0000_0010, 32'h0000_0010},
    '{OFS_INT_EN, 32'h0000_00A5, 32'h0000_00A5},
    '{OFS_BIAS, 32'h0000_0005, 32'h0000_0055}};

  lrpbc_core dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ev, .fifo_empty, .fifo_data, .fifo_rd, .pal_valid,
    .pal_data, .pal_ready(), .pix_data, .pix_valid, .panel_clk(),
    .pclk_tick, .mode_raster, .raster_on, .actvid_blank, .restart,
    .irq);
  lrpbc_panel_src src (.mclk, .fill, .fifo_rd, .fifo_empty, .fifo_data,
    .pal_valid, .pal_data);

  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ***************************************************
  // bus and check tasks
  // ***************************************************
  task automatic give_verdict();
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [5:0] a, logic [31:0] e, string nm);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, e);
  endtask
  task automatic pulse(lrpbc_ev_t e);
    @(posedge mclk);
    ev <= e;
    @(posedge mclk);
    ev <= '0;
  endtask
  task automatic await(ref logic s, input logic v, input string nm);
    int n = 0;
    while (s !== v && n < 200) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(nm, {31'h0, s}, {31'h0, v});
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    fill <= 1'b0;
    rd(OFS_DIV, {24'h0, DIV_RST}, "div_rst");
    rd(OFS_RAW, 32'h0, "raw_rst");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "row");
    end
    wr(OFS_INT_EN, 32'h0);
    pulse(6'h20);
    rd(OFS_RAW, 32'h1, "raw_xfer");
    rd(OFS_MASKED, 32'h0, "masked_off");
    chk("irq_off", {31'h0, irq}, 32'h0);
    wr(OFS_INT_EN, 32'h1);
    wr(OFS_SEL, 32'h1);
    rd(OFS_QUERY, 32'h1, "query_m");
    chk("irq_on", {31'h0, irq}, 32'h1);
    wr(OFS_RAW, 32'h1);
    rd(OFS_RAW, 32'h0, "raw_clr");
    // passive mono, raster mode running without starting the engine
    wr(OFS_RCFG, 32'h5);
    wr(OFS_CTRL, 32'h4);
    wr(OFS_CTRL, 32'h5);
    @(posedge pclk_tick) #1 gap = cyc;
    @(posedge pclk_tick) #1 chk("tick_gap", cyc - gap, 32'h0000_0010);
    wr(OFS_BIAS, 32'h2);
    pulse(6'h01);
    rd(OFS_RAW, 32'h0, "bias_one");
    chk("mode", {31'h0, mode_raster}, 32'h1);
    pulse(6'h01);
    rd(OFS_QUERY, 32'h0, "bias_m");
    pulse(6'h01);
    rd(OFS_BIAS, 32'h22, "bias_halt");
    wr(OFS_SEL, 32'h0);
    rd(OFS_QUERY, 32'h8, "bias_raw");
    wr(OFS_RAW, 32'h8);
    wr(OFS_BIAS, 32'h0);
    repeat (3) pulse(6'h01);
    rd(OFS_RAW, 32'h0, "bias_zero");
    // unpacked 24-bit, pixel data only
    wr(OFS_RCFG, 32'h41);
    wr(OFS_CTRL, 32'h5);
    await(pix_valid, 1'b1, "pix_valid");
    chk("pix", {8'h0, pix_data}, 32'h00C3_0004);
    await(raster_on, 1'b0, "uflow_stop");
    rd(OFS_RAW, 32'h10, "uflow");
    wr(OFS_RAW, 32'h10);
    @(posedge mclk);
    fill <= 1'b1;
    @(posedge mclk);
    fill <= 1'b0;
    wr(OFS_CTRL, 32'h7);
    await(restart, 1'b1, "restart");
    wr(OFS_RCFG, 32'h41);
    await(raster_on, 1'b0, "rcfg_stop");
    pulse(6'h10);
    rd(OFS_RAW, 32'h12, "frame");
    wr(OFS_RAW, 32'hFF);
    // 8 bpp palette only, two wait cycles per burst
    wr(OFS_RCFG, 32'h1693);
    wr(OFS_CTRL, 32'h5);
    repeat (400) @(posedge mclk);
    rd(OFS_RAW, 32'h20, "pal_done");
    chk("actvid", {31'h0, actvid_blank}, 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
